// >>> rtl/rsfr_master.v
// Serial RTU master that issues table and register reads and checks replies
`include "rsfr_defines.vh"
`default_nettype none

module rsfr_master #(
  parameter MAX_OUT_PT      = 16'd2048,  // Highest output point number
  parameter MAX_IN_PT       = 16'd2048,  // Highest input point number
  parameter MAX_REG         = 16'd1024,  // Highest register number
  parameter RESP_TIMEOUT_US = 16'd1000,  // Reply silence limit in microseconds
  parameter FIFO_DEPTH      = 16,
  parameter FIFO_AW         = 4
) (
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire        cmd_valid,
  output reg         cmd_ready_r,
  input  wire [7:0]  cmd_station,
  input  wire [7:0]  cmd_func,
  input  wire [15:0] cmd_start,
  input  wire [15:0] cmd_count,
  output reg  [7:0]  tx_byte_r,
  output reg         tx_valid_r,
  input  wire        tx_ready,
  input  wire [7:0]  rx_byte,
  input  wire        rx_valid,
  output reg         rx_ready_r,
  output reg         done_r,
  output reg  [2:0]  status_r,
  output reg  [7:0]  info_r,
  output wire [7:0]  rd_data_r,
  output wire        rd_valid_r,
  input  wire        rd_ready
);

  localparam S_IDLE = 2'b00;  // Waiting for a command
  localparam S_TX   = 2'b01;  // Sending the query
  localparam S_RX   = 2'b10;  // Collecting the reply

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // CRC-16 over one byte, LSB first
  function [15:0] crc_upd;
    input [15:0] c;
    input [7:0]  b;
    integer      k;
    reg   [15:0] t;
    begin
      t = c ^ {8'h00, b};
      for (k = 0; k < 8; k = k + 1) begin
        t = t[0] ? ((t >> 1) ^ `RSFR_CRC_POLY) : (t >> 1);
      end
      crc_upd = t;
    end
  endfunction

  // Reply length without CRC from function code and count byte
  function [8:0] resp_len;
    input [7:0] fc;
    input [7:0] b3;
    begin
      if (fc[7]) begin
        resp_len = `RSFR_LEN_HDR;
      end else begin
        case (fc)
          `RSFR_FC_RD_OUT, `RSFR_FC_RD_IN:
            resp_len = (b3 == 8'h00) ? (`RSFR_LEN_HDR + `RSFR_LEN_256)
                                     : (`RSFR_LEN_HDR + {1'b0, b3});
          `RSFR_FC_RD_REG, `RSFR_FC_RD_ANA, `RSFR_FC_SCRATCH:
            resp_len = `RSFR_LEN_HDR + {1'b0, b3};
          `RSFR_FC_FORCE1, `RSFR_FC_PRESET1, `RSFR_FC_LOOPBACK,
          `RSFR_FC_FORCEN, `RSFR_FC_PRESETN:
            resp_len = `RSFR_LEN_SIX;
          `RSFR_FC_EXC_STAT:
            resp_len = `RSFR_LEN_HDR;
          `RSFR_FC_DEV_TYPE, `RSFR_FC_MASK_WR:
            resp_len = `RSFR_LEN_EIGHT;
          `RSFR_FC_RW_REG:
            resp_len = `RSFR_LEN_RW_HDR + {1'b0, b3};
          default:
            resp_len = `RSFR_LEN_HDR;
        endcase
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  reg  [1:0]            state_r;     // Sequencer state
  reg  [8:0]            idx_r;       // Byte index within frame
  reg  [15:0]           crc_r;       // Running CRC
  reg  [7:0]            station_r;   // Addressed station
  reg  [7:0]            func_r;      // Function code in use
  reg  [15:0]           start_r;     // Start field
  reg  [15:0]           count_r;     // Count field
  reg  [8:0]            exp_len_r;   // Expected reply length less CRC
  reg                   exc_r;       // Reply is an exception
  reg                   mism_r;      // Reply header disagrees with query
  reg  [`RSFR_TICK_W-1:0] tick_cnt_r; // Microsecond divider
  reg                   tick_r;      // One-cycle microsecond pulse
  reg  [`RSFR_TMO_W-1:0]  tmo_r;     // Microseconds since last reply byte
  wire [FIFO_AW:0]      fifo_lvl;    // FIFO fill level
  wire                  rx_acc;      // Reply byte taken
  wire                  tx_acc;      // Query byte taken
  wire                  cmd_acc;     // Command taken
  wire [15:0]           crc_rx;      // CRC including current reply byte
  wire [15:0]           crc_tx;      // CRC including current query byte; unchanged over the two CRC bytes
  wire [15:0]           sel_max;     // Highest number for the selected table
  wire [16:0]           cmd_sum;     // Start plus count
  wire                  cmd_ok;      // Command is a legal read query
  wire [16:0]           cnt_round;   // Point count rounded up to bytes
  wire [7:0]            exp_bc;      // Count byte the reply must carry
  wire                  push;        // Data byte goes to the FIFO

  assign cmd_acc = cmd_valid && cmd_ready_r;
  assign tx_acc  = tx_valid_r && tx_ready;
  assign rx_acc  = rx_valid && rx_ready_r && (state_r == S_RX);
  assign crc_rx  = crc_upd(crc_r, rx_byte);
  assign crc_tx  = (idx_r[2:0] <= `RSFR_LEN_QUERY) ? crc_upd(crc_r, tx_byte_r) : crc_r;

  // Query legality per table
  assign sel_max = (cmd_func == `RSFR_FC_RD_OUT) ? MAX_OUT_PT :
                   (cmd_func == `RSFR_FC_RD_IN)  ? MAX_IN_PT  : MAX_REG;
  assign cmd_sum = {1'b0, cmd_start} + {1'b0, cmd_count};
  assign cmd_ok  = (cmd_station != `RSFR_BCAST_ADDR)
                && ((cmd_func == `RSFR_FC_RD_OUT) || (cmd_func == `RSFR_FC_RD_IN)
                    || (cmd_func == `RSFR_FC_RD_REG))
                && (cmd_count != 16'h0000)
                && (cmd_start < sel_max)
                && (cmd_sum <= {1'b0, sel_max})
                && ((cmd_func == `RSFR_FC_RD_REG) ? (cmd_count <= `RSFR_REG_CNT_MAX)
                                                  : (cmd_count <= `RSFR_PT_CNT_MAX));

  // Expected reply count byte
  assign cnt_round = {1'b0, count_r} + `RSFR_PT_ROUND;
  assign exp_bc    = (func_r == `RSFR_FC_RD_REG) ? {count_r[6:0], 1'b0}
                                                 : cnt_round[10:3];

  // Data bytes pass through untouched; packing and byte order are kept
  assign push = rx_acc && (idx_r >= `RSFR_IDX_DATA) && (idx_r < exp_len_r)
             && !exc_r && !mism_r;

  //////////////////////////////////////////////////////////////////////////////
  // Microsecond tick divider
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_r <= {`RSFR_TICK_W{1'b0}};
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == (`RSFR_TICK_CYC - 1)) begin
      tick_cnt_r <= {`RSFR_TICK_W{1'b0}};
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r     <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Query send, reply check and completion report
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r     <= S_IDLE;
      idx_r       <= 9'h000;
      crc_r       <= `RSFR_CRC_INIT;
      station_r   <= 8'h00;
      func_r      <= 8'h00;
      start_r     <= 16'h0000;
      count_r     <= 16'h0000;
      exp_len_r   <= `RSFR_LEN_UNKNOWN;
      exc_r       <= 1'b0;
      mism_r      <= 1'b0;
      tmo_r       <= {`RSFR_TMO_W{1'b0}};
      cmd_ready_r <= 1'b0;
      tx_byte_r   <= 8'h00;
      tx_valid_r  <= 1'b0;
      rx_ready_r  <= 1'b0;
      done_r      <= 1'b0;
      status_r    <= `RSFR_ST_OK;
      info_r      <= 8'h00;
    end else begin
      done_r     <= 1'b0;
      rx_ready_r <= (state_r == S_RX) && (fifo_lvl <= (FIFO_DEPTH - 2));
      case (state_r)
        S_IDLE: begin
          cmd_ready_r <= 1'b1;
          if (cmd_acc) begin
            cmd_ready_r <= 1'b0;
            if (cmd_ok) begin
              // Latch the query and present the address byte
              station_r  <= cmd_station;
              func_r     <= cmd_func;
              start_r    <= cmd_start;
              count_r    <= cmd_count;
              idx_r      <= 9'h000;
              crc_r      <= `RSFR_CRC_INIT;
              tx_byte_r  <= cmd_station;
              tx_valid_r <= 1'b1;
              state_r    <= S_TX;
            end else begin
              // Illegal query is never sent
              done_r   <= 1'b1;
              status_r <= `RSFR_ST_BAD_CMD;
              info_r   <= 8'h00;
            end
          end
        end
        S_TX: begin
          if (tx_acc) begin
            crc_r <= crc_tx;
            idx_r <= idx_r + 1'b1;
            case (idx_r[2:0])
              3'h0: tx_byte_r <= func_r;
              3'h1: tx_byte_r <= start_r[15:8];
              3'h2: tx_byte_r <= start_r[7:0];
              3'h3: tx_byte_r <= count_r[15:8];
              3'h4: tx_byte_r <= count_r[7:0];
              3'h5: tx_byte_r <= crc_tx[7:0];
              3'h6: tx_byte_r <= crc_r[15:8];
              default: tx_byte_r <= 8'h00;
            endcase
            if (idx_r[2:0] == `RSFR_LEN_FRAME_END) begin
              // Query out; start listening for the reply
              tx_valid_r <= 1'b0;
              idx_r      <= 9'h000;
              crc_r      <= `RSFR_CRC_INIT;
              exp_len_r  <= `RSFR_LEN_UNKNOWN;
              exc_r      <= 1'b0;
              mism_r     <= 1'b0;
              tmo_r      <= {`RSFR_TMO_W{1'b0}};
              state_r    <= S_RX;
            end
          end
        end
        S_RX: begin
          if (rx_acc) begin
            crc_r <= crc_rx;
            idx_r <= idx_r + 1'b1;
            tmo_r <= {`RSFR_TMO_W{1'b0}};
            if (idx_r == `RSFR_IDX_ADDR) begin
              if (rx_byte != station_r) begin
                mism_r <= 1'b1;
              end
            end else if (idx_r == `RSFR_IDX_FUNC) begin
              if (rx_byte[7]) begin
                exc_r     <= 1'b1;
                exp_len_r <= `RSFR_LEN_HDR;
              end else if (rx_byte != func_r) begin
                mism_r <= 1'b1;
              end
            end else if (idx_r == `RSFR_IDX_COUNT) begin
              info_r <= rx_byte;
              if (!exc_r) begin
                exp_len_r <= resp_len(func_r, rx_byte);
                if (rx_byte != exp_bc) begin
                  mism_r <= 1'b1;
                end
              end
            end
            // Index passes the length only at the last CRC byte; unknown length never wraps
            if (idx_r > exp_len_r) begin
              // Last CRC byte: residue zero means good
              state_r     <= S_IDLE;
              rx_ready_r  <= 1'b0;
              done_r      <= 1'b1;
              if (crc_rx != 16'h0000) begin
                status_r <= `RSFR_ST_CRC;
              end else if (exc_r) begin
                status_r <= `RSFR_ST_EXCEPT;
              end else if (mism_r) begin
                status_r <= `RSFR_ST_MISMATCH;
              end else begin
                status_r <= `RSFR_ST_OK;
              end
            end
          end else if (tick_r) begin
            if (tmo_r == RESP_TIMEOUT_US - 1'b1) begin
              // Silent station; reads never target broadcast so a reply is due
              state_r    <= S_IDLE;
              rx_ready_r <= 1'b0;
              done_r     <= 1'b1;
              status_r   <= `RSFR_ST_TIMEOUT;
            end else begin
              tmo_r <= tmo_r + 1'b1;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reply data buffer
  rsfr_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .in_valid    (push),
    .in_ready    (),
    .in_data     (rx_byte),
    .out_valid_r (rd_valid_r),
    .out_ready   (rd_ready),
    .out_data_r  (rd_data_r),
    .level_r     (fifo_lvl)
  );

endmodule // rsfr_master

`default_nettype wire

// >>> rtl/rsfr_defines.vh
// Shared constants for the serial RTU read master; the data FIFO uses none of them
`ifndef RSFR_DEFINES_VH
`define RSFR_DEFINES_VH

// Clock and time base
`define RSFR_CLK_PERIOD_NS   50
`define RSFR_TICK_NS         1000
`define RSFR_TICK_CYC        (`RSFR_TICK_NS / `RSFR_CLK_PERIOD_NS)
`define RSFR_TICK_W          5
`define RSFR_TMO_W           16

// CRC-16 seed and reflected polynomial
`define RSFR_CRC_INIT        16'hffff
`define RSFR_CRC_POLY        16'ha001

// Function codes
`define RSFR_FC_RD_OUT       8'h01
`define RSFR_FC_RD_IN        8'h02
`define RSFR_FC_RD_REG       8'h03
`define RSFR_FC_RD_ANA       8'h04
`define RSFR_FC_FORCE1       8'h05
`define RSFR_FC_PRESET1      8'h06
`define RSFR_FC_EXC_STAT     8'h07
`define RSFR_FC_LOOPBACK     8'h08
`define RSFR_FC_FORCEN       8'h0f
`define RSFR_FC_PRESETN      8'h10
`define RSFR_FC_DEV_TYPE     8'h11
`define RSFR_FC_MASK_WR      8'h16
`define RSFR_FC_RW_REG       8'h17
`define RSFR_FC_SCRATCH      8'h43

// Frame lengths without CRC, and last query byte indices
`define RSFR_LEN_QUERY       3'h5
`define RSFR_LEN_FRAME_END   3'h7
`define RSFR_LEN_HDR         9'h003
`define RSFR_LEN_RW_HDR      9'h005
`define RSFR_LEN_SIX         9'h006
`define RSFR_LEN_EIGHT       9'h008
`define RSFR_LEN_UNKNOWN     9'h1ff
`define RSFR_LEN_256         9'h100

// Field positions within the reply
`define RSFR_IDX_ADDR        9'h000
`define RSFR_IDX_FUNC        9'h001
`define RSFR_IDX_COUNT       9'h002
`define RSFR_IDX_DATA        9'h003

// Query limits
`define RSFR_BCAST_ADDR      8'h00
`define RSFR_REG_CNT_MAX     16'h007d
`define RSFR_PT_CNT_MAX      16'h0800
`define RSFR_PT_ROUND        17'h00007

// Completion status codes
`define RSFR_ST_OK           3'h0
`define RSFR_ST_BAD_CMD      3'h1
`define RSFR_ST_TIMEOUT      3'h2
`define RSFR_ST_CRC          3'h3
`define RSFR_ST_EXCEPT       3'h4
`define RSFR_ST_MISMATCH     3'h5

`endif

// >>> rtl/rsfr_fifo.v
// Data FIFO with a registered output stage
`default_nettype none

module rsfr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys,
  input  wire             arst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid_r,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data_r,
  output reg  [AW:0]      level_r
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];  // Storage array
  reg [AW-1:0]    wr_ptr_r;         // Write pointer
  reg [AW-1:0]    rd_ptr_r;         // Read pointer
  wire            push;             // Word written this cycle
  wire            pop;              // Word moved to output stage

  assign in_ready = (level_r != DEPTH[AW:0]);
  assign push     = in_valid && in_ready;
  assign pop      = (level_r != {(AW+1){1'b0}}) && (!out_valid_r || out_ready);

  ////////////////////////////////////////////////////////////////////////////
  // Storage write, no reset needed for the array
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers, fill level and output stage
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r    <= {AW{1'b0}};
      rd_ptr_r    <= {AW{1'b0}};
      level_r     <= {(AW+1){1'b0}};
      out_valid_r <= 1'b0;
      out_data_r  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r   <= rd_ptr_r + 1'b1;
        out_data_r <= mem[rd_ptr_r];
      end
      // Output stage holds a word until the reader takes it
      if (pop) begin
        out_valid_r <= 1'b1;
      end else if (out_ready) begin
        out_valid_r <= 1'b0;
      end
      level_r <= level_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule // rsfr_fifo

`default_nettype wire

// >>> verif/rsfr_master_assertions.sv
// Port-level checker for the serial read master
`default_nettype none
module rsfr_master_checker (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready_r,
  input wire logic [7:0]  cmd_station,
  input wire logic [7:0]  cmd_func,
  input wire logic [15:0] cmd_start,
  input wire logic [15:0] cmd_count,
  input wire logic [7:0]  tx_byte_r,
  input wire logic        tx_valid_r,
  input wire logic        tx_ready,
  input wire logic [7:0]  rx_byte,
  input wire logic        rx_valid,
  input wire logic        rx_ready_r,
  input wire logic        done_r,
  input wire logic [2:0]  status_r,
  input wire logic [7:0]  info_r,
  input wire logic [7:0]  rd_data_r,
  input wire logic        rd_valid_r,
  input wire logic        rd_ready
);
  logic [3:0] ntx_r;  // Query bytes sent since the last command
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  // Count query bytes handed to the transmitter
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) ntx_r <= 4'h0;
    else if (cmd_valid && cmd_ready_r) ntx_r <= 4'h0;
    else if (tx_valid_r && tx_ready) ntx_r <= ntx_r + 4'h1;
  end
  ////////////////////////////////////////
  // Command accepted
  sequence s_take;
    cmd_valid && cmd_ready_r;
  endsequence
  // Command that is plainly illegal
  sequence s_bad;
    s_take ##0 (cmd_station == 8'h00 || cmd_func == 8'h00 || cmd_func > 8'h03 || cmd_count == 16'h0000);
  endsequence
  property p_take_busy; s_take |=> !cmd_ready_r; endproperty
  a_take_busy: assert property (p_take_busy) else $error("ready stayed high after a take");
  property p_bad_cmd; s_bad |=> done_r && status_r == 3'h1 && info_r == 8'h00 && !tx_valid_r; endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("illegal command not refused");
  property p_reg_cnt; s_take ##0 (cmd_func == 8'h03 && cmd_count > 16'd125) |=> done_r && status_r == 3'h1; endproperty
  a_reg_cnt: assert property (p_reg_cnt) else $error("oversized register count accepted");
  property p_first_byte; s_take ##1 tx_valid_r |-> tx_byte_r == $past(cmd_station); endproperty
  a_first_byte: assert property (p_first_byte) else $error("query does not open with station");
  property p_tx_hold; tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_byte_r); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("query byte changed before taken");
  property p_done_pulse; done_r |=> !done_r && cmd_ready_r; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");
  property p_idle; cmd_ready_r |-> !rx_ready_r && !tx_valid_r; endproperty
  a_idle: assert property (p_idle) else $error("link active while idle");
  property p_rd_hold; rd_valid_r && !rd_ready |=> rd_valid_r && $stable(rd_data_r); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped before taken");
  property p_len; done_r |-> ntx_r == 4'h0 || ntx_r == 4'h8; endproperty
  a_len: assert property (p_len) else $error("query length not eight bytes");
endmodule  // rsfr_master_checker

bind rsfr_master rsfr_master_checker u_chk (.clk_sys, .arst_n, .cmd_valid, .cmd_ready_r, .cmd_station,
  .cmd_func, .cmd_start, .cmd_count, .tx_byte_r, .tx_valid_r, .tx_ready, .rx_byte, .rx_valid, .rx_ready_r,
  .done_r, .status_r, .info_r, .rd_data_r, .rd_valid_r, .rd_ready);
`default_nettype wire

// >>> verif/rsfr_slave_model.sv
// Behavioural slave station answering table and register reads
`default_nettype none
module rsfr_slave_model #(
  parameter int MOUT = 64,  // Highest output point
  parameter int MINP = 48,  // Highest input point
  parameter int MREG = 200  // Highest register
) (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  output var  logic       tx_ready,
  output var  logic [7:0] rx_byte,
  output var  logic       rx_valid,
  input  wire logic       rx_ready,
  input  wire logic       slow,     // Stall both directions
  input  wire logic       exc,      // Answer with an exception
  input  wire logic       bad_crc,  // Corrupt the reply check
  input  wire logic       mute,     // Stay silent
  output var  logic       q_err     // Malformed query seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];    // Query bytes
  logic [7:0] rsp[$];  // Reply bytes still to send
  logic [1:0] cyc;     // Stall pacing
  int         gap;     // Turnaround delay
  ////////////////////////////////////////
  // Reflected CRC over a byte queue
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  // Table contents by number
  function automatic logic [15:0] reg_val(input int n);
    return 16'(n * 291 + 165);
  endfunction
  function automatic logic pt_val(input int fc, input int n);
    return ((n * 5 + fc) % 3) == 0;
  endfunction
  // Check the query and queue the reply
  task automatic answer;
    int st, cn, mx;
    logic [7:0] b;
    logic [15:0] c;
    st = {q[2], q[3]};
    cn = {q[4], q[5]};
    mx = q[1] == 8'h01 ? MOUT : q[1] == 8'h02 ? MINP : MREG;
    if (crc16(q[0:5]) != {q[7], q[6]} || q[0] == 8'h00 || q[1] < 8'h01 || q[1] > 8'h03) q_err <= 1'b1;
    if (st >= mx || st + cn > mx || cn == 0 || (q[1] == 8'h03 && cn > 125)) q_err <= 1'b1;
    rsp = {q[0]};
    b = 8'h00;
    if (exc) begin
      rsp.push_back(q[1] | 8'h80);
      rsp.push_back(8'h02);
    end else if (q[1] == 8'h03) begin
      rsp.push_back(q[1]);
      rsp.push_back(8'(2 * cn));
      for (int i = 0; i < cn; i++) begin
        c = reg_val(st + i + 1);
        rsp.push_back(c[15:8]);
        rsp.push_back(c[7:0]);
      end
    end else begin
      rsp.push_back(q[1]);
      rsp.push_back(8'((cn + 7) / 8));
      for (int i = 0; i < (cn + 7) / 8 * 8; i++) begin
        b[i % 8] = i < cn && pt_val(q[1], st + i + 1);
        if (i % 8 == 7) rsp.push_back(b);
      end
    end
    c = crc16(rsp) ^ {15'h0000, bad_crc};
    rsp.push_back(c[7:0]);
    rsp.push_back(c[15:8]);
    if (mute || q[0] == 8'h00) rsp = {};
  endtask
  ////////////////////////////////////////
  // Collect the query, then send the reply byte by byte
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_byte  <= 8'h00;
      q_err    <= 1'b0;
      cyc      <= 2'h0;
      gap = 0;
      q = {};
      rsp = {};
    end else begin
      cyc <= cyc + 2'h1;
      tx_ready <= !slow || cyc == 2'h0;
      if (tx_valid && tx_ready) begin
        q.push_back(tx_byte);
        if (q.size() == 8) begin
          answer();
          q = {};
          gap = 4;
        end
      end
      if (rx_valid && !rx_ready) begin
        // Hold the offered byte until taken
      end else if (rsp.size() > 0 && gap == 0 && (!slow || cyc[0])) begin
        rx_valid <= 1'b1;
        rx_byte  <= rsp.pop_front();
      end else begin
        rx_valid <= 1'b0;
        rx_byte  <= ~rx_byte;  // Released line shows no stale value
      end
      if (gap > 0) gap--;
    end
  end
endmodule  // rsfr_slave_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the serial read master
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MOUT = 64;   // Highest output point
  localparam int MINP = 48;   // Highest input point
  localparam int MREG = 200;  // Highest register
  logic        clk_sys, arst_n, cmd_valid, cmd_ready_r, tx_valid_r, tx_ready, rx_valid, rx_ready_r;
  logic        done_r, rd_valid_r, rd_ready, slow, exc, bad_crc, mute, q_err;
  logic [7:0]  cmd_station, cmd_func, tx_byte_r, rx_byte, info_r, rd_data_r;
  logic [15:0] cmd_start, cmd_count;
  logic [2:0]  status_r;
  logic [7:0]  exp_q[$], got_q[$];  // Expected and received data
  logic [47:0] bad[11];             // Illegal commands
  int          errors, n_checks, f, mx, c;
  rsfr_master #(.MAX_OUT_PT(16'd64), .MAX_IN_PT(16'd48), .MAX_REG(16'd200), .RESP_TIMEOUT_US(16'd5)) uut (
    .clk_sys, .arst_n, .cmd_valid, .cmd_ready_r, .cmd_station, .cmd_func, .cmd_start, .cmd_count, .tx_byte_r,
    .tx_valid_r, .tx_ready, .rx_byte, .rx_valid, .rx_ready_r, .done_r, .status_r, .info_r, .rd_data_r,
    .rd_valid_r, .rd_ready);
  rsfr_slave_model #(.MOUT(MOUT), .MINP(MINP), .MREG(MREG)) u_dev (.clk_sys, .arst_n, .tx_byte(tx_byte_r),
    .tx_valid(tx_valid_r), .tx_ready, .rx_byte, .rx_valid, .rx_ready(rx_ready_r), .slow, .exc, .bad_crc, .mute,
    .q_err);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  // Bench copy of the table contents
  function automatic logic [15:0] reg_val(input int n);
    return 16'(n * 291 + 165);
  endfunction
  function automatic logic pt_val(input int fc, input int n);
    return ((n * 5 + fc) % 3) == 0;
  endfunction
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Drain the data FIFO with random stalls
  task automatic reader;
    forever begin
      @(posedge clk_sys);
      if (rd_valid_r === 1'b1 && rd_ready === 1'b1) got_q.push_back(rd_data_r);
      rd_ready <= ($urandom % 4) != 0;
    end
  endtask
  // Issue one command and compare its outcome with the bench model
  task automatic run_cmd(input logic [7:0] st, input logic [7:0] fc, input int sp, input int cn, input logic [2:0] es);
    int n;
    logic [7:0] b, ei;
    logic [15:0] w;
    exp_q = {};
    got_q = {};
    b = 8'h00;
    ei = es == 3'h1 ? 8'h00 : es == 3'h4 ? 8'h02 : fc == 8'h03 ? 8'(2 * cn) : 8'((cn + 7) / 8);
    for (int i = 0; i < cn && (es == 3'h0 || es == 3'h3); i++) begin
      if (fc == 8'h03) begin
        w = reg_val(sp + i + 1);
        exp_q.push_back(w[15:8]);
        exp_q.push_back(w[7:0]);
      end else begin
        b[i % 8] = pt_val(fc, sp + i + 1);
        if (i % 8 == 7 || i == cn - 1) exp_q.push_back(b & (8'hff >> (7 - i % 8)));
      end
    end
    cmd_valid   <= 1'b1;
    cmd_station <= st;
    cmd_func    <= fc;
    cmd_start   <= 16'(sp);
    cmd_count   <= 16'(cn);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cmd_ready_r !== 1'b1 && n < 100);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (done_r !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      errors++;
      tally_and_finish();
    end
    check("status", status_r, es);
    if (es != 3'h2) check("count byte", info_r, ei);
    n = 0;
    while ((got_q.size() < exp_q.size() || rd_valid_r === 1'b1) && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    check("data words", got_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < got_q.size()) check("data", got_q[i], exp_q[i]);
    check("query form", q_err, 1'b0);
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h3621383b));
    {cmd_valid, cmd_station, cmd_func, cmd_start, cmd_count, rd_ready, slow, exc, bad_crc, mute} = '0;
    arst_n = 1'b0;
    bad = '{{8'h00, 8'h03, 32'd1}, {8'h11, 8'h00, 32'd1}, {8'h11, 8'h04, 32'd1}, {8'h11, 8'h80, 32'd1},
           {8'h11, 8'h09, 32'd1}, {8'h11, 8'h03, 32'd126}, {8'h11, 8'h01, 16'd64, 16'd1},
           {8'h11, 8'h02, 16'd45, 16'd4}, {8'h11, 8'h03, 16'd198, 16'd3}, {8'h11, 8'h03, 16'd200, 16'd1},
           {8'h11, 8'h01, 32'd0}};
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    fork
      reader();
    join_none
    @(posedge clk_sys);
    run_cmd(8'h11, 8'h03, 0, 1, 3'h0);
    run_cmd(8'h11, 8'h03, MREG - 125, 125, 3'h0);
    run_cmd(8'h22, 8'h01, 5, 13, 3'h0);
    run_cmd(8'h22, 8'h02, 0, MINP, 3'h0);
    run_cmd(8'h22, 8'h01, MOUT - 1, 1, 3'h0);
    foreach (bad[i]) run_cmd(bad[i][47:40], bad[i][39:32], bad[i][31:16], bad[i][15:0], 3'h1);
    exc <= 1'b1;
    run_cmd(8'h33, 8'h02, 8, 20, 3'h4);
    exc <= 1'b0;
    bad_crc <= 1'b1;
    run_cmd(8'h33, 8'h03, 10, 7, 3'h3);
    bad_crc <= 1'b0;
    mute <= 1'b1;
    run_cmd(8'h33, 8'h01, 0, 8, 3'h2);
    mute <= 1'b0;
    slow <= 1'b1;
    repeat (12) begin
      f = 1 + $urandom % 3;
      mx = f == 1 ? MOUT : f == 2 ? MINP : MREG;
      c = 1 + $urandom % (f == 3 ? 125 : mx);
      run_cmd(8'(1 + $urandom % 247), 8'(f), $urandom % (mx - c + 1), c, 3'h0);
    end
    arst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    run_cmd(8'h44, 8'h03, MREG - 1, 1, 3'h0);
    tally_and_finish();
  end
endmodule  // testbench
`default_nettype wire
